// >>> hw/rsp_ctrl.sv
// Ramp phase and spread-spectrum control registers and ramp
// How it works
// - Two-bit field picks one of four phases
// - Audio lock bit aligns PWM to frame
// - Align enable turns phase sync on, reset 0
// - Halving bit halves source clock in manual
// - Manual bit makes ramp fields take effect
// - Random enable adds spread within range field
// - Triangle enable adds sweep set by field
// - Manual ramp frequency is reference over divisor
// - Fall step shortens ramp period in triangle sweep
// - Rise step lengthens ramp period in triangle sweep
// - Amplitude field sets ramp amplitude in manual
// - Boundary field limits triangle sweep excursion
module rsp_ctrl
   import rsp_pkg::*;
(
   // Clock and reset
   input  wire logic          ref_clk_i,
   input  wire logic          rst_i,
   // Register port from the serial control bus
   input  wire logic          reg_wr_i,
   input  wire logic          reg_rd_i,
   input  wire logic [7:0]    reg_addr_i,
   input  wire logic [7:0]    reg_wdata_i,
   output logic [7:0]         reg_rdata_o,
   output logic               reg_ack_o,
   // Amplifier state and sync sources
   input  wire logic          play_i,
   input  wire logic          frame_sync_i,
   input  wire logic          phase_sync_i,
   // Ramp
   output rsp_pkg::rsp_ramp_t ramp_o,
   output logic [1:0]         active_phase_o
);
   import rsp_pkg::*;

   typedef struct packed {
      logic [7:0] r_phase;
      logic [7:0] r_ss0;
      logic [7:0] r_ss1;
      logic [7:0] r_ss2;
      logic [7:0] r_ss3;
      logic [7:0] r_ss4;
      logic [7:0] rdata;
      logic       ack;
      logic [1:0] act_phase;
   } rsp_regs_t;

   rsp_regs_t q, next_q;
   rsp_cfg_t  cfg;
   logic      sync_ev;

   always_comb begin
      next_q = q;
      next_q.ack = reg_wr_i || reg_rd_i;
      if (reg_wr_i) begin
         if (reg_addr_i == ADDR_PHASE) begin
            next_q.r_phase = reg_wdata_i;
         end else if (reg_addr_i == ADDR_SS0) begin
            next_q.r_ss0 = reg_wdata_i;
         end else if (reg_addr_i == ADDR_SS1) begin
            next_q.r_ss1 = reg_wdata_i;
         end else if (reg_addr_i == ADDR_SS2) begin
            next_q.r_ss2 = reg_wdata_i;
         end else if (reg_addr_i == ADDR_SS3) begin
            next_q.r_ss3 = reg_wdata_i;
         end else if (reg_addr_i == ADDR_SS4) begin
            next_q.r_ss4 = reg_wdata_i;
         end
      end
      if (reg_rd_i) begin
         if (reg_addr_i == ADDR_PHASE) begin
            next_q.rdata = q.r_phase;
         end else if (reg_addr_i == ADDR_SS0) begin
            next_q.rdata = q.r_ss0;
         end else if (reg_addr_i == ADDR_SS1) begin
            next_q.rdata = q.r_ss1;
         end else if (reg_addr_i == ADDR_SS2) begin
            next_q.rdata = q.r_ss2;
         end else if (reg_addr_i == ADDR_SS3) begin
            next_q.rdata = q.r_ss3;
         end else if (reg_addr_i == ADDR_SS4) begin
            next_q.rdata = q.r_ss4;
         end else begin
            next_q.rdata = 8'h00;
         end
      end
      // Phase is captured outside play; changes during play are held off
      if (!play_i) begin
         next_q.act_phase = q.r_phase[PH_SEL_HI:PH_SEL_LO];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         q <= '{r_phase: RST_PHASE, r_ss0: RST_SS0, r_ss1: RST_SS1,
                r_ss2: RST_SS2, r_ss3: RST_SS3, r_ss4: RST_SS4,
                rdata: 8'h00, ack: 1'b0, act_phase: 2'h0};
      end else begin
         q <= next_q;
      end
   end

   always_comb begin
      cfg.phase_sel        = q.act_phase;
      cfg.audio_lock       = q.r_phase[PH_AUDIO_B];
      cfg.align_en         = q.r_phase[PH_ALIGN_B];
      cfg.half_src         = q.r_ss0[SS_HALF_B];
      cfg.manual           = q.r_ss0[SS_MAN_B];
      cfg.spread_random_on = q.r_ss0[SS_RDM_B];
      cfg.tri_on           = q.r_ss0[SS_TRI_B];
      cfg.random_spread_range = q.r_ss1[RDM_HI:RDM_LO];
      cfg.tri_ctrl         = q.r_ss1[TRI_HI:TRI_LO];
      cfg.ramp_freq_divisor = q.r_ss2;
      cfg.triangle_fall_step = q.r_ss3[FALL_HI:FALL_LO];
      cfg.triangle_rise_step = q.r_ss3[RISE_HI:RISE_LO];
      cfg.ramp_amplitude_setting = q.r_ss4[AMP_HI:AMP_LO];
      cfg.triangle_sweep_bound = q.r_ss4[BND_HI:BND_LO];
   end

   // Either enabled source realigns the ramp
   assign sync_ev = (cfg.audio_lock && frame_sync_i)
                    || (cfg.align_en && phase_sync_i);

   rsp_ramp_gen u_gen (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .cfg_i     (cfg),
      .run_i     (play_i),
      .sync_i    (sync_ev),
      .ramp_o    (ramp_o)
   );

   assign reg_rdata_o    = q.rdata;
   assign reg_ack_o      = q.ack;
   assign active_phase_o = q.act_phase;

   phase_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (play_i && $past(play_i)) |-> $stable(q.act_phase))
      else $error("phase changed during play");
   no_sync_off_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (!q.r_phase[PH_AUDIO_B] && !q.r_phase[PH_ALIGN_B]) |-> !sync_ev)
      else $error("sync while disabled");
   reset_div_a: assert property (@(posedge ref_clk_i)
      $fell(rst_i) |-> q.r_ss2 == RST_SS2 && q.r_ss4 == RST_SS4)
      else $error("reset value wrong");
   write_read_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (reg_wr_i && reg_addr_i == ADDR_SS3 && !reg_rd_i)
      ##1 (reg_rd_i && reg_addr_i == ADDR_SS3 && !reg_wr_i)
      |=> reg_rdata_o == $past(reg_wdata_i, 2))
      else $error("register readback wrong");
   read_ack_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      reg_rd_i |=> reg_ack_o)
      else $error("read not acknowledged");

   // A write strobe with no read beside it
   sequence rsp_wr_seq;
      reg_wr_i && !reg_rd_i;
   endsequence
   write_ack_a: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      rsp_wr_seq |=> reg_ack_o)
      else $error("write not acknowledged");
   // Divisor write lands on the taking edge
   div_write_a: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      (rsp_wr_seq and (reg_addr_i == ADDR_SS2))
      |=> q.r_ss2 == $past(reg_wdata_i))
      else $error("divisor write not applied");
   // Outside play the phase in use follows the register field
   phase_track_a: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      !play_i |=> q.act_phase == $past(q.r_phase[PH_SEL_HI:PH_SEL_LO]))
      else $error("phase selection not taken while idle");
endmodule

// >>> hw/rsp_pkg.sv
// Package for the ramp phase and spread-spectrum control block
package rsp_pkg;
   // Register offsets (byte addresses on the control bus)
   localparam logic [7:0] ADDR_PHASE = 8'h6A;
   localparam logic [7:0] ADDR_SS0   = 8'h6B;
   localparam logic [7:0] ADDR_SS1   = 8'h6C;
   localparam logic [7:0] ADDR_SS2   = 8'h6D;
   localparam logic [7:0] ADDR_SS3   = 8'h6E;
   localparam logic [7:0] ADDR_SS4   = 8'h6F;
   // Reset values
   localparam logic [7:0] RST_PHASE  = 8'h00;
   localparam logic [7:0] RST_SS0    = 8'h00;
   localparam logic [7:0] RST_SS1    = 8'h00;
   localparam logic [7:0] RST_SS2    = 8'h50;
   localparam logic [7:0] RST_SS3    = 8'h11;
   localparam logic [7:0] RST_SS4    = 8'h24;
   // Field positions
   localparam int PH_SEL_LO   = 2;
   localparam int PH_SEL_HI   = 3;
   localparam int PH_AUDIO_B  = 1;
   localparam int PH_ALIGN_B  = 0;
   localparam int SS_HALF_B   = 5;
   localparam int SS_MAN_B    = 4;
   localparam int SS_RDM_B    = 1;
   localparam int SS_TRI_B    = 0;
   localparam int RDM_LO      = 4;
   localparam int RDM_HI      = 6;
   localparam int TRI_LO      = 0;
   localparam int TRI_HI      = 3;
   localparam int FALL_LO     = 4;
   localparam int FALL_HI     = 7;
   localparam int RISE_LO     = 0;
   localparam int RISE_HI     = 3;
   localparam int AMP_LO      = 5;
   localparam int AMP_HI      = 6;
   localparam int BND_LO      = 0;
   localparam int BND_HI      = 4;
   // Nominal ramp reference: frequency = REF_HZ / divisor
   localparam int unsigned RAMP_REF_HZ = 61440000;
   // Automatic-mode divisor, triangle and amplitude defaults
   localparam logic [7:0] AUTO_DIV   = 8'h50;
   localparam logic [3:0] AUTO_STEP  = 4'h1;
   localparam logic [4:0] AUTO_BND   = 5'h04;
   localparam logic [1:0] AUTO_AMP   = 2'h1;
   // Random generator seed (any nonzero value)
   localparam logic [15:0] LFSR_SEED = 16'hACE1;

   typedef enum logic [1:0] {
      RSP_FIXED,
      RSP_TRI,
      RSP_RDM,
      RSP_BOTH
   } rsp_mode_t;

   // Settings that steer the ramp generator
   typedef struct packed {
      logic [1:0] phase_sel;
      logic       audio_lock;
      logic       align_en;
      logic       half_src;
      logic       manual;
      logic       spread_random_on;
      logic       tri_on;
      logic [2:0] random_spread_range;
      logic [3:0] tri_ctrl;
      logic [7:0] ramp_freq_divisor;
      logic [3:0] triangle_fall_step;
      logic [3:0] triangle_rise_step;
      logic [1:0] ramp_amplitude_setting;
      logic [4:0] triangle_sweep_bound;
   } rsp_cfg_t;

   // Ramp output bundle
   typedef struct packed {
      logic       ramp_tick;
      logic [1:0] phase;
      logic [1:0] amplitude;
      logic [8:0] period;
      rsp_mode_t  mode;
   } rsp_ramp_t;
endpackage

// >>> hw/rsp_ramp_gen.sv
// Ramp period generator with triangle and random spreading
module rsp_ramp_gen
   import rsp_pkg::*;
(
   // Clock and reset
   input  wire logic          ref_clk_i,
   input  wire logic          rst_i,
   // Settings and sync events
   input  rsp_pkg::rsp_cfg_t  cfg_i,
   input  wire logic          run_i,
   input  wire logic          sync_i,
   // Ramp
   output rsp_pkg::rsp_ramp_t ramp_o
);
   import rsp_pkg::*;

   typedef struct packed {
      logic [8:0]  cnt;
      logic [8:0]  period;
      logic signed [6:0] offs;
      logic        down;
      logic [15:0] lfsr;
      logic        src_half;
      logic        tick;
      logic [1:0]  tri_div;
   } rsp_gen_t;

   rsp_gen_t q, next_q;
   logic [7:0] div;
   logic [3:0] up_step, dn_step;
   logic [4:0] bnd;
   logic signed [9:0] bnd_s;
   logic [8:0] phase_off;
   logic [8:0] rdm;
   logic       src_en;
   logic signed [9:0] tri_sum;
   rsp_mode_t mode;

   always_comb begin
      // Automatic mode uses a fixed divisor, fixed steps and a fixed bound; those fields act only in manual
      div     = cfg_i.manual ? cfg_i.ramp_freq_divisor : AUTO_DIV;
      up_step = cfg_i.manual ? cfg_i.triangle_rise_step : AUTO_STEP;
      dn_step = cfg_i.manual ? cfg_i.triangle_fall_step : AUTO_STEP;
      bnd     = cfg_i.manual ? cfg_i.triangle_sweep_bound : AUTO_BND;
      // Divide-by-zero guard: divisor 0 acts as 1
      if (div == 8'h00) begin
         div = 8'h01;
      end
      // Signed copy keeps the sweep compare from wrapping below zero
      bnd_s = 10'(signed'({1'b0, bnd}));
      mode = rsp_mode_t'({cfg_i.spread_random_on, cfg_i.tri_on});
      // Quarter-period offsets give four staggered phases
      phase_off = 9'(({1'b0, div} >> 2) * cfg_i.phase_sel);
      rdm = 9'(q.lfsr[8:0] & ((9'h001 << cfg_i.random_spread_range)
                              - 9'h001));
      // Halved source advances every other cycle in manual mode
      src_en = !(cfg_i.manual && cfg_i.half_src) || q.src_half;
      tri_sum = 10'(signed'(q.offs)) + (q.down ? -10'(signed'({1'b0, dn_step}))
                : 10'(signed'({1'b0, up_step})));
      next_q = q;
      next_q.tick = 1'b0;
      next_q.src_half = !q.src_half;
      next_q.lfsr = {q.lfsr[14:0],
                     q.lfsr[15] ^ q.lfsr[13] ^ q.lfsr[12] ^ q.lfsr[10]};
      if (!run_i) begin
         next_q.cnt = phase_off;
         next_q.offs = '0;
         next_q.period = {1'b0, div};
      end else if (sync_i) begin
         next_q.cnt = phase_off;
      end else if (src_en) begin
         if (q.cnt + 9'h001 >= q.period) begin
            next_q.cnt = '0;
            next_q.tick = 1'b1;
            next_q.tri_div = q.tri_div + 2'h1;
            // Triangle steps once every four ramp periods, whatever the frequency/range field
            if (mode[0] && q.tri_div == 2'h0) begin
               if (tri_sum >= bnd_s) begin
                  next_q.down = 1'b1;
                  next_q.offs = 7'(bnd);
               end else if (tri_sum <= -bnd_s) begin
                  next_q.down = 1'b0;
                  next_q.offs = -7'(bnd);
               end else begin
                  next_q.offs = 7'(tri_sum);
               end
            end else if (!mode[0]) begin
               next_q.offs = '0;
            end
            next_q.period = 9'(10'({1'b0, div}) + 10'(signed'(next_q.offs))
                            + 10'(mode[1] ? rdm : 9'h000)
                            + 10'(mode[0] ? cfg_i.tri_ctrl : 4'h0));
            if (next_q.period == 9'h000) begin
               next_q.period = 9'h001;
            end
         end else begin
            next_q.cnt = q.cnt + 9'h001;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         q <= '{cnt: '0, period: {1'b0, RST_SS2}, offs: '0, down: 1'b0,
                lfsr: LFSR_SEED, src_half: 1'b0, tick: 1'b0,
                tri_div: '0};
      end else begin
         q <= next_q;
      end
   end

   assign ramp_o = '{ramp_tick: q.tick, phase: cfg_i.phase_sel,
                     amplitude: cfg_i.manual ? cfg_i.ramp_amplitude_setting
                                : AUTO_AMP,
                     period: q.period, mode: mode};

   fixed_period_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (run_i && $past(mode) == RSP_FIXED && q.tick)
      |-> q.period == $past({1'b0, div}))
      else $error("fixed ramp period differs from divisor");
   sync_realign_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (run_i && sync_i) |=> q.cnt == $past(phase_off))
      else $error("sync did not realign ramp count");
   tri_bound_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      mode[0] |-> (10'(signed'(q.offs)) <= bnd_s + 10'sd15
                   && 10'(signed'(q.offs)) >= -bnd_s - 10'sd15))
      else $error("triangle offset out of bound");
endmodule

// >>> test/rsp_host_model.sv
// Host controller model that drives the register port and play level
module rsp_host_model (
   // Clock
   input  wire logic       ref_clk_i,
   // Register port
   output logic            reg_wr_o,
   output logic            reg_rd_o,
   output logic [7:0]      reg_addr_o,
   output logic [7:0]      reg_wdata_o,
   input  wire logic [7:0] reg_rdata_i,
   input  wire logic       reg_ack_i,
   // Amplifier state
   output logic            play_o
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      reg_wr_o    = 1'b0;
      reg_rd_o    = 1'b0;
      reg_addr_o  = 8'hFF;
      reg_wdata_o = 8'hFF;
      play_o      = 1'b0;
   end

   // Request stands until its acknowledge is seen; chain starts at once
   task automatic acc(input logic wr, input logic chain,
                      input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic ok);
      int n;
      if (!chain) begin
         @(posedge ref_clk_i);
      end
      #1;
      reg_wr_o    = wr;
      reg_rd_o    = !wr;
      reg_addr_o  = a;
      reg_wdata_o = d;
      ok = 1'b0;
      q  = 8'h00;
      // The taking edge still shows the acknowledge of an earlier strobe
      @(posedge ref_clk_i);
      for (n = 0; n < 8 && !ok; n++) begin
         @(posedge ref_clk_i);
         ok = reg_ack_i;
         q  = reg_rdata_i;
      end
      #1;
      reg_wr_o    = 1'b0;
      reg_rd_o    = 1'b0;
      // Released lines show the inverse so stale values never match
      reg_addr_o  = ~a;
      reg_wdata_o = ~d;
   endtask

   // Play is only changed by the host, after the phase is set up
   task automatic set_play(input logic p);
      @(posedge ref_clk_i);
      #1;
      play_o = p;
   endtask
endmodule

// >>> test/tb_class_d_ramp_spread_phase_ctrl.sv
// Self-checking bench for the ramp phase and spread-spectrum block
module tb_class_d_ramp_spread_phase_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   import rsp_pkg::*;

   localparam logic [7:0] REG_AD [6] = '{ADDR_PHASE, ADDR_SS0, ADDR_SS1,
                                         ADDR_SS2, ADDR_SS3, ADDR_SS4};
   localparam logic [7:0] REG_RV [6] = '{RST_PHASE, RST_SS0, RST_SS1,
                                         RST_SS2, RST_SS3, RST_SS4};
   // Triangle bias field and random span used by the mode scenario
   localparam logic [8:0] TRI_BIAS = 9'h005;
   localparam logic [8:0] RDM_SPAN = 9'h007;

   logic       clk;
   logic       rst;
   logic       wr, rd, ack, play, fsync, psync;
   logic [7:0] addr, wdata, rdata;
   logic [1:0] act_ph;
   rsp_ramp_t  ramp;
   int         err_count;
   int         total_checks;

   rsp_ctrl rsp_ctrl_inst (.ref_clk_i(clk), .rst_i(rst), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_rdata_o(rdata), .reg_ack_o(ack), .play_i(play),
      .frame_sync_i(fsync), .phase_sync_i(psync), .ramp_o(ramp),
      .active_phase_o(act_ph));

   rsp_host_model rsp_host_model_inst (.ref_clk_i(clk), .reg_wr_o(wr),
      .reg_rd_o(rd), .reg_addr_o(addr), .reg_wdata_o(wdata),
      .reg_rdata_i(rdata), .reg_ack_i(ack), .play_o(play));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic test_done();
      $display("checks=%0d errors=%0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk_val(input string nm, input logic [8:0] e,
                          input logic [8:0] g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s exp=%h got=%h", nm, e, g);
      end
   endtask

   task automatic chk_mode(input string nm, input rsp_mode_t e,
                           input rsp_mode_t g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s exp=%0d got=%0d", nm, e, g);
      end
   endtask

   task automatic chk_rng(input string nm, input logic [8:0] lo,
                          input logic [8:0] hi, input logic [8:0] g);
      total_checks++;
      if ($isunknown(g) || g < lo || g > hi) begin
         err_count++;
         $display("[FAIL] %s exp=%h..%h got=%h", nm, lo, hi, g);
      end
   endtask

   task automatic xfer(input logic w, input logic c, input logic [7:0] a,
                       input logic [7:0] d, output logic [7:0] q);
      logic ok;
      rsp_host_model_inst.acc(w, c, a, d, q, ok);
      if (ok !== 1'b1) begin
         err_count++;
         $display("[FAIL] ack exp=1 got=%b", ok);
         test_done();
      end
   endtask

   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      xfer(1'b1, 1'b0, a, d, q);
   endtask

   task automatic rchk(input string nm, input logic [7:0] a,
                       input logic [7:0] e);
      logic [7:0] q;
      xfer(1'b0, 1'b0, a, 8'h00, q);
      chk_val(nm, {1'b0, e}, {1'b0, q});
   endtask

   task automatic pulse_sync(input logic f, input logic p);
      @(posedge clk);
      #1;
      fsync = f;
      psync = p;
      @(posedge clk);
      #1;
      fsync = 1'b0;
      psync = 1'b0;
   endtask

   // Bounded wait for the next ramp tick; n is the cycle count waited
   task automatic tick_gap(output int n);
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (ramp.ramp_tick !== 1'b1 && n < 2000);
      if (n >= 2000) begin
         err_count++;
         $display("[FAIL] ramp tick exp=1 got=0");
         test_done();
      end
   endtask

   task automatic t_regs();
      for (int i = 0; i < 6; i++) begin
         rchk("reset value", REG_AD[i], REG_RV[i]);
      end
      for (int i = 0; i < 6; i++) begin
         wreg(REG_AD[i], 8'hA5 ^ 8'(i));
         rchk("readback", REG_AD[i], 8'hA5 ^ 8'(i));
         wreg(REG_AD[i], REG_RV[i]);
      end
      // Unmapped place: write is dropped, read returns zero
      wreg(8'h70, 8'hFF);
      rchk("unmapped", 8'h70, 8'h00);
   endtask

   // Write and read of one register in consecutive cycles
   task automatic t_b2b();
      logic [7:0] q;
      xfer(1'b1, 1'b0, ADDR_SS3, 8'h33, q);
      xfer(1'b0, 1'b1, ADDR_SS3, 8'h00, q);
      chk_val("write then read", 9'h033, {1'b0, q});
      wreg(ADDR_SS3, RST_SS3);
   endtask

   // Mid-run reset brings the changed settings back
   task automatic t_reset();
      @(posedge clk);
      #1;
      rst = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      rst = 1'b0;
      rchk("reset divisor", ADDR_SS2, RST_SS2);
      rchk("reset bound", ADDR_SS4, RST_SS4);
   endtask

   task automatic t_phase();
      for (int p = 3; p >= 0; p--) begin
         wreg(ADDR_PHASE, {4'h0, 2'(p), 2'b00});
         repeat (2) @(posedge clk);
         chk_val("phase", 9'(p), {7'h00, act_ph});
         chk_val("ramp phase", 9'(p), {7'h00, ramp.phase});
      end
      rsp_host_model_inst.set_play(1'b1);
      wreg(ADDR_PHASE, 8'h0C);
      repeat (4) @(posedge clk);
      chk_val("phase held in play", 9'h000, {7'h00, act_ph});
   endtask

   task automatic t_mode();
      int n;
      logic [8:0] lo;
      logic [8:0] hi;
      // Random range 3 and triangle bias 5 make every spread visible
      wreg(ADDR_SS1, 8'h35);
      for (int m = 0; m < 4; m++) begin
         wreg(ADDR_SS0, {6'h00, 2'(m)});
         tick_gap(n);
         tick_gap(n);
         chk_mode("mode", rsp_mode_t'(m), ramp.mode);
         lo = {1'b0, AUTO_DIV}
              + ((m % 2) == 1 ? TRI_BIAS - {4'h0, AUTO_BND} : 9'h000);
         hi = {1'b0, AUTO_DIV}
              + ((m % 2) == 1 ? TRI_BIAS + {4'h0, AUTO_BND} : 9'h000)
              + (m >= 2 ? RDM_SPAN : 9'h000);
         chk_rng("mode period", lo, hi, ramp.period);
      end
      wreg(ADDR_SS1, RST_SS1);
   endtask

   task automatic t_manual();
      int n1;
      int n2;
      wreg(ADDR_SS2, 8'h20);
      wreg(ADDR_SS4, 8'h44);
      wreg(ADDR_SS0, 8'h10);
      tick_gap(n1);
      tick_gap(n1);
      chk_val("manual period", 9'h020, ramp.period);
      chk_val("manual gap", 9'h020, 9'(n1));
      chk_val("manual amp", 9'h002, {7'h00, ramp.amplitude});
      // Halved source: same period value, twice the tick spacing
      wreg(ADDR_SS0, 8'h30);
      tick_gap(n2);
      tick_gap(n2);
      chk_val("half gap", 9'h040, 9'(n2));
      wreg(ADDR_SS0, 8'h00);
      tick_gap(n1);
      tick_gap(n1);
      chk_val("auto period", {1'b0, AUTO_DIV}, ramp.period);
      chk_val("auto amp", {7'h00, AUTO_AMP}, {7'h00, ramp.amplitude});
   endtask

   // Sync reloads the count to a quarter period per phase step
   task automatic t_sync();
      int n;
      rsp_host_model_inst.set_play(1'b0);
      wreg(ADDR_PHASE, 8'h0A);
      rsp_host_model_inst.set_play(1'b1);
      pulse_sync(1'b1, 1'b0);
      tick_gap(n);
      chk_val("frame sync gap", 9'(AUTO_DIV - 2 * (AUTO_DIV >> 2)),
              9'(n));
      wreg(ADDR_PHASE, 8'h09);
      pulse_sync(1'b0, 1'b1);
      tick_gap(n);
      chk_val("phase sync gap", 9'(AUTO_DIV - 2 * (AUTO_DIV >> 2)),
              9'(n));
      tick_gap(n);
      chk_val("period after sync", {1'b0, AUTO_DIV}, ramp.period);
   endtask

   initial begin
      err_count    = 0;
      total_checks = 0;
      rst          = 1'b1;
      fsync        = 1'b0;
      psync        = 1'b0;
      repeat (5) @(posedge clk);
      #1;
      rst = 1'b0;
      t_regs();
      t_b2b();
      t_phase();
      t_mode();
      t_manual();
      t_sync();
      t_reset();
      test_done();
   end
endmodule
